// File: rtl/mcs_params.svh
// Constants of the main clock select and prescale block.
// Assumes inclusion by bare name from the design file.
`ifndef MCS_PARAMS_SVH
`define MCS_PARAMS_SVH
// Register indices, byte address is four times the index
`define MCS_IDX_CTRLA 8'h00
`define MCS_IDX_CTRLB 8'h01
`define MCS_IDX_LOCK 8'h02
`define MCS_IDX_STATUS 8'h03
`define MCS_IDX_FASTCTRL 8'h10
`define MCS_IDX_CALA 8'h11
`define MCS_IDX_CALB 8'h12
`define MCS_IDX_LPCTRL 8'h18
`define MCS_IDX_XTALCTRL 8'h1C
`define MCS_IDX_KEY 8'h3F
// Field positions
`define MCS_CLKOUT_BIT 7
`define MCS_PEN_BIT 0
`define MCS_PRESCALE_RATIO_FIELD_LSB 1
`define MCS_STDBY_BIT 1
`define MCS_XENABLE_BIT 0
`define MCS_XSEL_BIT 2
`define MCS_CRYSTAL_STARTUP_TIME_FIELD_LSB 4
`define MCS_CALB_LOCK_BIT 7
`define MCS_ST_EXT_BIT 7
`define MCS_ST_XTAL_BIT 6
`define MCS_ST_LP_BIT 5
`define MCS_ST_FAST_BIT 4
`define MCS_ST_SW_BIT 0
// Reset values
`define MCS_RST_PRESCALE_RATIO_FIELD 4'h8
`define MCS_RST_PEN 1'b1
// Timing counts
`define MCS_RC_START_EDGES 17'h00004
`define MCS_EXT_START_EDGES 17'h00002
`define MCS_KEY_WIN 3'h4
`define MCS_LP_TICK_LAST 5'h1F
`endif

// File: rtl/mcs_pkg.sv
// Types of the main clock select and prescale block.
// Assumes nothing beyond a SystemVerilog compiler.
package mcs_pkg;
  typedef enum logic [1:0] {
    MCS_SRC_FAST = 2'b00,
    MCS_SRC_LP = 2'b01,
    MCS_SRC_XTAL = 2'b10,
    MCS_SRC_EXT = 2'b11
  } mcs_src_t;

  typedef struct packed {
    logic freq20;
    logic trimLock;
    logic [5:0] cal;
    logic [3:0] tempCal;
  } mcs_fuse_t;

  typedef struct packed {
    logic fastRcRun;
    logic lpRcRun;
    logic xtalRun;
    logic xtalPinsOwned;
    logic extPinIsClock;
  } mcs_osc_en_t;

  typedef struct packed {
    logic [5:0] s1;
    logic [5:0] s2;
    logic [5:0] s3;
    logic [5:0] filt;
    logic fuseDone;
    logic freq20;
    logic trimLock;
    logic clkOut;
    logic [3:0] prescale_ratio_field;
    logic prescale_on_bit;
    logic lock_enable_bit;
    logic fastStdby;
    logic [5:0] cal;
    logic [3:0] tempCal;
    logic lpStdby;
    logic [1:0] xtalCsut;
    logic xtalSel;
    logic xtalStdby;
    logic xtalEn;
    logic [2:0] keyWin;
    mcs_src_t curSel;
    mcs_src_t tgtSel;
    logic switching;
    logic [3:0][16:0] edgeCnt;
    logic [3:0] started;
    logic [5:0] perCnt;
    logic perTick;
    logic [4:0] lpDiv;
    logic tick1k;
    mcs_osc_en_t oscEn;
    logic [31:0] prdata;
  } mcs_state_t;
endpackage

// File: rtl/mcs_clk_ctrl.sv
// Main clock source select, prescaler, start-up status and unlock.
// Assumes APB master on clk, oscillator levels arriving asynchronously.
//
// Contract
// - Run-time source change, unsafe changes blocked
// - External switch completes only after enough edges
// - Pending switch refuses further changes until handover
// - Switch flag set while change under way
// - Per-source running and stable status flags
// - Peripheral clock prescaled by 1 to 64
// - Reset selects fast RC, divide by six
// - Fast RC frequency from fuse at reset
// - Internal oscillators enabled on any request
// - Trim fields loaded from fuses at reset
// - Trim-lock fuse blocks calibration changes
// - Lock bit locks trim while fast RC main
// - Four edges after analog start-up for RCs
// - Low-power RC yields 1.024 kHz tick
// - Pin becomes clock input, two-edge start
// - Crystal enable takes over both crystal pins
// - Crystal waits programmed time, external mode two
// - Key write, then protected write within four
// - Unkeyed protected write leaves register unchanged
// - Source codes fast, low-power, crystal, pin
// - Ratio codes map to documented divisions
// - Prescaler off passes main clock undivided
`timescale 1ns/1ps
`include "mcs_params.svh"

module mcs_clk_ctrl
  import mcs_pkg::*;
#(
  parameter int ADDR_W = 12,
  parameter logic [7:0] KEY = 8'hA5,
  parameter logic [16:0] XTAL_SUT_BASE = 17'h00400
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] periphReq,
  input wire logic [3:0] oscLevel,
  input wire logic [1:0] rcAnalogReady,
  input wire mcs_fuse_t fuse,
  output mcs_osc_en_t oscEn,
  output mcs_src_t mainSel,
  output logic switchBusy,
  output logic perTick,
  output logic tick1k,
  output logic [5:0] calTrim,
  output logic [3:0] tempTrim,
  output logic freq20Mhz,
  output logic clkOutEnable
);

  mcs_state_t q;
  mcs_state_t n;
  logic [3:0] edgeSeen;
  logic [3:0] req;
  logic [3:0] run;
  logic [16:0] need;
  logic [16:0] xtalNeed;
  logic [6:0] div;
  logic [7:0] idx;
  logic [7:0] rd;
  logic mapped;
  logic wrAcc;
  logic unlocked;
  logic calLocked;

  // Reserved codes fall back to divide by two
  function automatic logic [6:0] divRatio(input logic [3:0] code);
    case (code)
      4'h0: divRatio = 7'h02;
      4'h1: divRatio = 7'h04;
      4'h2: divRatio = 7'h08;
      4'h3: divRatio = 7'h10;
      4'h4: divRatio = 7'h20;
      4'h5: divRatio = 7'h40;
      4'h8: divRatio = 7'h06;
      4'h9: divRatio = 7'h0A;
      4'hA: divRatio = 7'h0C;
      4'hB: divRatio = 7'h18;
      4'hC: divRatio = 7'h30;
      default: divRatio = 7'h02;
    endcase
  endfunction

  function automatic logic regMapped(input logic [7:0] i);
    case (i)
      `MCS_IDX_CTRLA, `MCS_IDX_CTRLB, `MCS_IDX_LOCK, `MCS_IDX_STATUS,
      `MCS_IDX_FASTCTRL, `MCS_IDX_CALA, `MCS_IDX_CALB, `MCS_IDX_LPCTRL,
      `MCS_IDX_XTALCTRL, `MCS_IDX_KEY: regMapped = 1'b1;
      default: regMapped = 1'b0;
    endcase
  endfunction

  assign idx = paddr[9:2];
  assign mapped = regMapped(idx) && (paddr[1:0] == 2'h0)
    && (paddr[ADDR_W-1:10] == '0);
  assign wrAcc = psel && penable && pwrite && pstrb[0] && mapped
    && q.fuseDone;
  assign unlocked = (q.keyWin != 3'h0);
  assign calLocked = q.trimLock
    || (q.curSel == MCS_SRC_FAST && q.lock_enable_bit);

  always_comb
  begin
    case (idx)
      `MCS_IDX_CTRLA: rd = {q.clkOut, 5'h00,
        q.switching ? q.tgtSel : q.curSel};
      `MCS_IDX_CTRLB: rd = {3'h0, q.prescale_ratio_field, q.prescale_on_bit};
      `MCS_IDX_LOCK: rd = {7'h00, q.lock_enable_bit};
      `MCS_IDX_STATUS: rd = {q.started[3], q.started[2], q.started[1],
        q.started[0], 3'h0, q.switching};
      `MCS_IDX_FASTCTRL: rd = {6'h00, q.fastStdby, 1'b0};
      `MCS_IDX_CALA: rd = {2'h0, q.cal};
      `MCS_IDX_CALB: rd = {q.trimLock, 3'h0, q.tempCal};
      `MCS_IDX_LPCTRL: rd = {6'h00, q.lpStdby, 1'b0};
      `MCS_IDX_XTALCTRL: rd = {2'h0, q.xtalCsut, 1'b0, q.xtalSel,
        q.xtalStdby, q.xtalEn};
      `MCS_IDX_KEY: rd = {7'h00, unlocked};
      default: rd = 8'h00;
    endcase
  end

  always_comb
  begin
    n = q;
    // Only s2 and s3 are compared, s1 feeds s2 alone
    n.s1 = {rcAnalogReady, oscLevel};
    n.s2 = q.s1;
    n.s3 = q.s2;
    for (int b = 0; b < 6; b++)
    begin
      if (q.s2[b] == q.s3[b])
      begin
        n.filt[b] = q.s3[b];
      end
    end
    edgeSeen = n.filt[3:0] & ~q.filt[3:0];

    // Fuses are caught on the first edge after release
    if (!q.fuseDone)
    begin
      n.fuseDone = 1'b1;
      n.freq20 = fuse.freq20;
      n.trimLock = fuse.trimLock;
      n.lock_enable_bit = fuse.trimLock;
      n.cal = fuse.cal;
      n.tempCal = fuse.tempCal;
    end

    for (int s = 0; s < 4; s++)
    begin
      req[s] = periphReq[s] || (q.curSel == 2'(s))
        || (q.switching && q.tgtSel == 2'(s));
    end
    req[0] = req[0] || q.fastStdby;
    req[1] = req[1] || q.lpStdby;
    req[2] = req[2] || q.xtalStdby;
    run = req;
    run[2] = req[2] && q.xtalEn;

    xtalNeed = q.xtalSel ? `MCS_EXT_START_EDGES
      : 17'(XTAL_SUT_BASE << {q.xtalCsut, 1'b0});
    for (int s = 0; s < 4; s++)
    begin
      case (s)
        0, 1: need = `MCS_RC_START_EDGES;
        2: need = xtalNeed;
        default: need = `MCS_EXT_START_EDGES;
      endcase
      if (!run[s])
      begin
        n.edgeCnt[s] = 17'h00000;
        n.started[s] = 1'b0;
      end
      else if (!q.started[s] && edgeSeen[s] && (s > 1 || q.filt[4 + s % 2]))
      begin
        n.edgeCnt[s] = q.edgeCnt[s] + 17'h00001;
        if (n.edgeCnt[s] >= need)
        begin
          n.started[s] = 1'b1;
        end
      end
    end

    // Handover only once the target has shown its edges
    if (q.switching && q.started[q.tgtSel])
    begin
      n.curSel = q.tgtSel;
      n.switching = 1'b0;
    end

    div = divRatio(q.prescale_ratio_field);
    n.perTick = !q.prescale_on_bit
      || ({1'b0, q.perCnt} >= div - 7'h01);
    n.perCnt = n.perTick ? 6'h00 : q.perCnt + 6'h01;

    n.tick1k = 1'b0;
    if (edgeSeen[1] && q.started[1])
    begin
      n.lpDiv = q.lpDiv + 5'h01;
      n.tick1k = (q.lpDiv == `MCS_LP_TICK_LAST);
    end

    if (q.keyWin != 3'h0)
    begin
      n.keyWin = q.keyWin - 3'h1;
    end

    if (psel && !penable)
    begin
      n.prdata = {24'h000000, rd};
    end

    if (wrAcc && idx != `MCS_IDX_STATUS)
    begin
      if (idx == `MCS_IDX_KEY)
      begin
        if (pwdata[7:0] == KEY)
        begin
          n.keyWin = `MCS_KEY_WIN;
        end
      end
      else
      begin
        // Window is spent by one protected write
        n.keyWin = 3'h0;
        if (unlocked)
        begin
          case (idx)
            `MCS_IDX_CTRLA:
            begin
              if (!q.lock_enable_bit)
              begin
                n.clkOut = pwdata[`MCS_CLKOUT_BIT];
                if (!q.switching && pwdata[1:0] != q.curSel)
                begin
                  n.tgtSel = mcs_src_t'(pwdata[1:0]);
                  n.switching = 1'b1;
                end
              end
            end
            `MCS_IDX_CTRLB:
            begin
              if (!q.lock_enable_bit)
              begin
                n.prescale_ratio_field = pwdata[`MCS_PRESCALE_RATIO_FIELD_LSB+:4];
                n.prescale_on_bit = pwdata[`MCS_PEN_BIT];
              end
            end
            `MCS_IDX_LOCK:
            begin
              if (!q.lock_enable_bit)
              begin
                n.lock_enable_bit = pwdata[0];
              end
            end
            `MCS_IDX_FASTCTRL: n.fastStdby = pwdata[`MCS_STDBY_BIT];
            `MCS_IDX_CALA:
            begin
              if (!calLocked)
              begin
                n.cal = pwdata[5:0];
              end
            end
            `MCS_IDX_CALB:
            begin
              if (!calLocked)
              begin
                n.tempCal = pwdata[3:0];
              end
            end
            `MCS_IDX_LPCTRL: n.lpStdby = pwdata[`MCS_STDBY_BIT];
            `MCS_IDX_XTALCTRL:
            begin
              n.xtalCsut = pwdata[`MCS_CRYSTAL_STARTUP_TIME_FIELD_LSB+:2];
              n.xtalSel = pwdata[`MCS_XSEL_BIT];
              n.xtalStdby = pwdata[`MCS_STDBY_BIT];
              n.xtalEn = pwdata[`MCS_XENABLE_BIT];
            end
            default: n.keyWin = 3'h0;
          endcase
        end
      end
    end

    n.oscEn.fastRcRun = run[0];
    n.oscEn.lpRcRun = run[1];
    n.oscEn.xtalRun = run[2];
    n.oscEn.xtalPinsOwned = q.xtalEn;
    n.oscEn.extPinIsClock = req[3];
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.curSel <= MCS_SRC_FAST;
      q.prescale_ratio_field <= `MCS_RST_PRESCALE_RATIO_FIELD;
      q.prescale_on_bit <= `MCS_RST_PEN;
    end
    else
    begin
      q <= n;
    end
  end

  assign prdata = q.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign oscEn = q.oscEn;
  assign mainSel = q.curSel;
  assign switchBusy = q.switching;
  assign perTick = q.perTick;
  assign tick1k = q.tick1k;
  assign calTrim = q.cal;
  assign tempTrim = q.tempCal;
  assign freq20Mhz = q.freq20;
  assign clkOutEnable = q.clkOut;

  AST_RESET_STATE: assert property (@(posedge clk) disable iff (!rst_n)
    !q.fuseDone |-> q.curSel == MCS_SRC_FAST && q.prescale_ratio_field == 4'h8 && q.prescale_on_bit)
    else $error("reset state not fast RC divide by six");

  AST_SW_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    q.switching && !q.started[q.tgtSel] |=> q.switching)
    else $error("switch flag dropped before handover");

  AST_SW_DONE: assert property (@(posedge clk) disable iff (!rst_n)
    q.switching && q.started[q.tgtSel]
      |=> !q.switching && q.curSel == $past(q.tgtSel))
    else $error("handover and flag clear not in one cycle");

  AST_SEL_CAUSE: assert property (@(posedge clk) disable iff (!rst_n)
    q.fuseDone && $changed(q.curSel)
      |-> $past(q.switching) && $past(q.started[q.tgtSel]))
    else $error("main source changed without started target");

  AST_REFUSE: assert property (@(posedge clk) disable iff (!rst_n)
    q.switching |=> q.tgtSel == $past(q.tgtSel))
    else $error("target changed while switch pending");

  AST_NO_KEY: assert property (@(posedge clk) disable iff (!rst_n)
    wrAcc && idx == `MCS_IDX_CTRLB && q.keyWin == 3'h0
      |=> $stable(q.prescale_ratio_field) && $stable(q.prescale_on_bit))
    else $error("prescaler written without unlock");

  AST_TRIM_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    q.fuseDone && q.trimLock |=> $stable(q.cal) && $stable(q.tempCal))
    else $error("trim changed under lock fuse");

  AST_CAL_LOCK: assert property (@(posedge clk) disable iff (!rst_n)
    q.fuseDone && q.lock_enable_bit && q.curSel == MCS_SRC_FAST |=> $stable(q.cal))
    else $error("trim changed while locked as main clock");

  AST_PEN_OFF: assert property (@(posedge clk) disable iff (!rst_n)
    !q.prescale_on_bit [*2] |-> q.perTick)
    else $error("undivided clock missed a tick");

  AST_DIV6: assert property (@(posedge clk) disable iff (!rst_n)
    (q.perTick && q.prescale_on_bit && q.prescale_ratio_field == 4'h8)
      ##1 (q.prescale_on_bit && q.prescale_ratio_field == 4'h8 && !q.perTick) [*5] |-> ##1 q.perTick)
    else $error("divide by six spacing wrong");

  AST_XTAL_PINS: assert property (@(posedge clk) disable iff (!rst_n)
    ##1 q.oscEn.xtalPinsOwned == $past(q.xtalEn))
    else $error("crystal pins not following enable");

  AST_XTAL_RUN: assert property (@(posedge clk) disable iff (!rst_n)
    !q.xtalEn |=> !q.oscEn.xtalRun && !q.started[2])
    else $error("crystal running while disabled");

endmodule

// File: tb/mcs_osc_model.sv
// Behavioural oscillators and pins on the far side of the clock block.
// Assumes the enables of the block arrive as one packed struct.
`timescale 1ns/1ps

module mcs_osc_model
  import mcs_pkg::*;
(
  input wire mcs_osc_en_t oscEn,
  input wire logic extDead,
  output logic [3:0] oscLevel,
  output logic [1:0] rcAnalogReady
);
  initial oscLevel = 4'h0;
  // Analog start-up modelled as a plain delay after enable
  assign #204 rcAnalogReady = {oscEn.lpRcRun, oscEn.fastRcRun};
  // Each source stands still while not running
  // Even periods keep pin edges off the rising clock edges
  always #30 if (oscEn.fastRcRun) oscLevel[0] = ~oscLevel[0];
  always #44 if (oscEn.lpRcRun) oscLevel[1] = ~oscLevel[1];
  always #56 if (oscEn.xtalRun) oscLevel[2] = ~oscLevel[2];
  // A dead pin keeps the pending switch stuck
  always #36 if (oscEn.extPinIsClock && !extDead)
    oscLevel[3] = ~oscLevel[3];
endmodule

// File: tb/tb_mcs_clk_ctrl.sv
// Self-checking bench of the clock select block over APB.
// Assumes the oscillator model drives the raw source levels.
`timescale 1ns/1ps
`define CHK(a, e) \
  begin num_checks++; if ((a) !== (e)) begin err_count++; \
  $display("[FAIL] %0t got %0h exp %0h", $time, (a), (e)); end end

module tb_mcs_clk_ctrl
  import mcs_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, switchBusy, perTick, tick1k;
  logic freq20Mhz, clkOutEnable;
  logic [3:0] req = 4'h0;
  logic [3:0] oscLevel;
  logic [1:0] rcReady;
  logic extDead = 1'b0;
  mcs_fuse_t fuse = {1'b1, 1'b0, 6'h2A, 4'h9};
  mcs_osc_en_t oscEn;
  mcs_src_t mainSel;
  logic [5:0] calTrim;
  logic [3:0] tempTrim;
  logic [31:0] d;
  logic e;
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;

  mcs_clk_ctrl #(.XTAL_SUT_BASE(17'h00004)) dut (.clk(clk),
    .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .periphReq(req), .oscLevel(oscLevel), .rcAnalogReady(rcReady),
    .fuse(fuse), .oscEn(oscEn), .mainSel(mainSel),
    .switchBusy(switchBusy), .perTick(perTick), .tick1k(tick1k),
    .calTrim(calTrim), .tempTrim(tempTrim), .freq20Mhz(freq20Mhz),
    .clkOutEnable(clkOutEnable));
  mcs_osc_model osc (.oscEn(oscEn), .extDead(extDead),
    .oscLevel(oscLevel), .rcAnalogReady(rcReady));

  always #5 clk = ~clk;

  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // Long enough for every scenario, short enough to cut a hang
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [7:0] wd);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, wd};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic kw(input logic [11:0] a, input logic [7:0] wd);
    apb(1'b1, 12'h0FC, 8'hA5);
    apb(1'b1, a, wd);
  endtask

  task automatic rst();
    rst_n <= 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask

  // Second gap measured; the first may straddle a ratio change
  task automatic perGap(output int n);
    repeat (2)
    begin
      n = 0;
      do @(posedge clk); while (perTick !== 1'b1);
      do begin @(posedge clk); n++; end while (perTick !== 1'b1 && n < 200);
    end
  endtask

  task automatic waitSel(input mcs_src_t s);
    for (int i = 0; i < 3000 && mainSel !== s; i++) @(posedge clk) #1;
  endtask

  task automatic tResetVals();
    apb(1'b0, 12'h000, 8'h00);
    `CHK(d, 32'h0);
    apb(1'b0, 12'h004, 8'h00);
    `CHK(d, 32'h11);
    `CHK(mainSel, MCS_SRC_FAST);
    `CHK(calTrim, fuse.cal);
    `CHK(tempTrim, fuse.tempCal);
    `CHK(freq20Mhz, fuse.freq20);
    apb(1'b0, 12'h014, 8'h00);
    `CHK(e, 1'b1);
  endtask

  task automatic tPrescale();
    int n;
    logic [3:0] codes [4] = '{4'h0, 4'h5, 4'h8, 4'hC};
    int divs [4] = '{2, 64, 6, 48};
    perGap(n);
    `CHK(n, 6);
    apb(1'b1, 12'h004, 8'h01);
    perGap(n);
    `CHK(n, 6);
    for (int i = 0; i < 4; i++)
    begin
      kw(12'h004, {3'h0, codes[i], 1'b1});
      perGap(n);
      `CHK(n, divs[i]);
    end
    kw(12'h004, 8'h0A);
    perGap(n);
    `CHK(n, 1);
    kw(12'h004, 8'h11);
  endtask

  task automatic tSwitchLp();
    @(posedge clk) req <= 4'h2;
    kw(12'h000, 8'h01);
    @(posedge clk) #1;
    `CHK(switchBusy, 1'b1);
    waitSel(MCS_SRC_LP);
    `CHK(mainSel, MCS_SRC_LP);
    `CHK(switchBusy, 1'b0);
    apb(1'b0, 12'h00C, 8'h00);
    `CHK(d[5], 1'b1);
    for (int i = 0; i < 3000 && tick1k !== 1'b1; i++) @(posedge clk) #1;
    `CHK(tick1k, 1'b1);
    kw(12'h000, 8'h00);
    waitSel(MCS_SRC_FAST);
    `CHK(mainSel, MCS_SRC_FAST);
  endtask

  task automatic tExtPending();
    @(posedge clk);
    extDead <= 1'b1;
    req <= 4'h8;
    kw(12'h000, 8'h03);
    repeat (300) @(posedge clk);
    #1;
    `CHK(mainSel, MCS_SRC_FAST);
    `CHK(switchBusy, 1'b1);
    `CHK(oscEn.extPinIsClock, 1'b1);
    kw(12'h000, 8'h01);
    apb(1'b0, 12'h000, 8'h00);
    `CHK(d[1:0], 2'h3);
    apb(1'b0, 12'h00C, 8'h00);
    `CHK(d[7], 1'b0);
    `CHK(mainSel, MCS_SRC_FAST);
    @(posedge clk) extDead <= 1'b0;
    waitSel(MCS_SRC_EXT);
    `CHK(mainSel, MCS_SRC_EXT);
    `CHK(switchBusy, 1'b0);
    apb(1'b0, 12'h00C, 8'h00);
    `CHK(d[7], 1'b1);
    kw(12'h070, 8'h05);
    @(posedge clk) req <= 4'hC;
    #1;
    `CHK(oscEn.xtalPinsOwned, 1'b1);
    kw(12'h000, 8'h02);
    waitSel(MCS_SRC_XTAL);
    `CHK(mainSel, MCS_SRC_XTAL);
    apb(1'b0, 12'h00C, 8'h00);
    `CHK(d[6], 1'b1);
  endtask

  task automatic tTrimLock();
    fuse.trimLock <= 1'b1;
    rst();
    kw(12'h044, 8'h15);
    apb(1'b0, 12'h044, 8'h00);
    `CHK(d, {26'h0, fuse.cal});
    `CHK(calTrim, fuse.cal);
    fuse.trimLock <= 1'b0;
    rst();
    kw(12'h004, 8'h0B);
    kw(12'h044, 8'h15);
    apb(1'b0, 12'h044, 8'h00);
    `CHK(calTrim, 6'h15);
    kw(12'h004, 8'h11);
    kw(12'h000, 8'h80);
    apb(1'b0, 12'h000, 8'h00);
    `CHK(d, 32'h80);
    `CHK(clkOutEnable, 1'b1);
    `CHK(switchBusy, 1'b0);
    kw(12'h008, 8'h01);
    kw(12'h044, 8'h0A);
    apb(1'b0, 12'h044, 8'h00);
    `CHK(calTrim, 6'h15);
    kw(12'h004, 8'h01);
    apb(1'b0, 12'h004, 8'h00);
    `CHK(d, 32'h11);
  endtask

  // Programmed crystal wait, sixteen edges with the reduced base
  task automatic tXtalSut();
    kw(12'h070, 8'h11);
    repeat (100) @(posedge clk);
    apb(1'b0, 12'h00C, 8'h00);
    `CHK(d[6], 1'b0);
    repeat (200) @(posedge clk);
    apb(1'b0, 12'h00C, 8'h00);
    `CHK(d[6], 1'b1);
  endtask

  initial
  begin
    rst();
    tResetVals();
    tPrescale();
    tSwitchLp();
    tExtPending();
    tTrimLock();
    tXtalSut();
    conclude();
  end
endmodule
